// ===== verilog/tws_consts.svh
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// ==========================================================
// Register offsets (word index on the plain register port)
`define TWS_A_CTL        3'h0
`define TWS_A_STAT       3'h1
`define TWS_A_DATA       3'h2
`define TWS_A_OWN        3'h3
`define TWS_A_EVT        3'h4
`define TWS_A_MSK        3'h5

// ==========================================================
// Control register bit positions
`define TWS_B_FLAG       7
`define TWS_B_EA         6
`define TWS_B_STA        5
`define TWS_B_STO        4
`define TWS_B_WC         3
`define TWS_B_EN         2

// ==========================================================
// Reset values
`define TWS_CORE_RST     '0
`define TWS_LINE_RST     '1

// ==========================================================
// Status codes
`define TWS_ST_SLA_R     8'hA8
`define TWS_ST_ARB_SLA_R 8'hB0
`define TWS_ST_DATA_ACK  8'hB8
`define TWS_ST_DATA_NACK 8'hC0
`define TWS_ST_LAST_ACK  8'hC8
`define TWS_ST_NOINFO    8'hF8
`define TWS_ST_BUSERR    8'h00

// ==========================================================
// Event bits
`define TWS_EV_JOB       3'h1
`define TWS_EV_ERR       3'h2
`define TWS_EV_START     3'h4

// ==========================================================
// Timing
`define TWS_CLK_NS          100
`define TWS_T_START_HOLD_NS 4000
`define TWS_START_HOLD_CYC  ((`TWS_T_START_HOLD_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)

`endif

// ===== verilog/tws_pkg.sv
package tws_pkg;

    // ==========================================================
    // Engine states, Gray along the read path
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_ADDR    = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_TX_BIT  = 3'h2,
        ST_TX_ACK  = 3'h6,
        ST_DONE    = 3'h7,
        ST_ERR     = 3'h5,
        ST_SGEN    = 3'h4
    } tws_state_t;

    // ==========================================================
    // Line monitor state: three sampled copies of {scl, sda}
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } tws_mon_t;

    // ==========================================================
    // Engine state
    typedef struct packed {
        tws_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] dat;
        logic [7:0] own;
        logic [7:0] code;
        logic       flag;
        logic       ack_en;
        logic       start_request;
        logic       stop_request;
        logic       wc;
        logic       en;
        logic       last;
        logic       ackv;
        logic       arb;
        logic       hold;
        logic       busy;
        logic       spend;
        logic [5:0] gcnt;
        logic [2:0] evt;
        logic [2:0] msk;
        logic [7:0] rdata;
        logic       sda_oe;
        logic       scl_oe;
        logic       irq;
    } tws_core_t;

endpackage

// ===== verilog/tws_line_if.sv
`timescale 1ns/10ps
// ==========================================================
// Sampled bus lines and their events
interface tws_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    modport mon  (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport core (input  scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

// ===== verilog/tws_line_mon.sv
`timescale 1ns/10ps
`include "tws_consts.svh"
module tws_line_mon
    import tws_pkg::*;
(
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    tws_line_if.mon   line
);

    tws_mon_t r;
    tws_mon_t n;

    // ==========================================================
    // Two-flop sync, third copy only for edge finding
    always_comb begin
        n    = r;
        n.s1 = {scl_in, sda_in};
        n.s2 = r.s1;
        n.s3 = r.s2;
    end

    // Reset to released lines so no false start appears
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= `TWS_LINE_RST;
        end else begin
            r <= n;
        end
    end

    // Edge and condition detection on synced copies only
    assign line.scl       = r.s2[1];
    assign line.sda       = r.s2[0];
    assign line.scl_rise  = r.s2[1] & ~r.s3[1];
    assign line.scl_fall  = ~r.s2[1] & r.s3[1];
    assign line.start_det = r.s2[1] & r.s3[1] & r.s3[0] & ~r.s2[0];
    assign line.stop_det  = r.s2[1] & r.s3[1] & ~r.s3[0] & r.s2[0];

endmodule

// ===== verilog/tws_slave_tx.sv
// Summary of operation
// - Own address with read bit acked sets the flag with code 0xA8 and starts transmitting.
// - Software loads data and clears the flag; acknowledge-enable low marks that byte as last.
// - Addressed for read after a lost master arbitration reports code 0xB0 instead.
// - A byte acked by the master sets the flag with code 0xB8 and waits for new data.
// - A byte not acked by the master sets the flag with code 0xC0.
// - A last byte that the master still acks sets the flag with code 0xC8.
// - Clearing the flag after 0xC0/0xC8 goes unaddressed; matching needs acknowledge-enable.
// - Start request written with that clear sends a START once the bus is free.
// - With the flag clear the status reads 0xF8.
// - START or STOP inside a byte, except during the first bit of a sent byte, or an acknowledge is a bus error with code 0x00.
// - Stop bit plus flag clear after an error goes unaddressed, clears stop, frees lines.
// - Once unaddressed after the last byte the block leaves data high for the master.
// - The low status bits read zero so codes compare unmasked.
// - While the flag is set, except after a bus error, the clock low period is stretched.
`timescale 1ns/10ps
`include "tws_consts.svh"
module tws_slave_tx
    import tws_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       arb_lost_in,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe_out,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            irq_out
);

    // START hold counted from zero, so the last count is one short
    localparam logic [5:0] HOLD_LAST = 6'(`TWS_START_HOLD_CYC - 1);

    // Whole engine state and its next value
    tws_core_t  r;
    tws_core_t  n;
    logic       bad;
    logic       quiet;
    logic       clr;
    tws_line_if line ();

    // ==========================================================
    // Line sampling
    tws_line_mon u_mon (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .line       (line)
    );

    // ==========================================================
    // Frame position checks
    // Inside a byte, except during the first bit of a sent byte, or on an acknowledge a START or STOP is illegal
    assign bad = ((r.st == ST_ADDR || r.st == ST_TX_BIT) && r.cnt != 4'h0) ||
                 r.st == ST_ADDR_ACK || r.st == ST_TX_ACK;
    assign quiet = r.en && !line.start_det && !line.stop_det;
    assign clr   = wr_in && addr_in == `TWS_A_CTL && wdata_in[`TWS_B_FLAG] && r.flag;

    // ==========================================================
    // Next state
    always_comb begin
        n       = r;
        n.rdata = 8'h00;

        // Register reads, data stands for one cycle only
        if (rd_in) begin
            case (addr_in)
                `TWS_A_CTL: begin
                    n.rdata = {r.flag, r.ack_en, r.start_request, r.stop_request, r.wc, r.en, 2'b00};
                end
                `TWS_A_STAT: begin
                    // Low three bits stand in for prescaler bits and read zero
                    n.rdata = r.flag ? {r.code[7:3], 3'b000} : `TWS_ST_NOINFO;
                end
                `TWS_A_DATA: n.rdata = r.dat;
                `TWS_A_OWN:  n.rdata = r.own;
                `TWS_A_EVT:  n.rdata = {5'h00, r.evt};
                `TWS_A_MSK:  n.rdata = {5'h00, r.msk};
                default:     n.rdata = 8'h00;
            endcase
        end

        // Register writes
        if (wr_in) begin
            case (addr_in)
                `TWS_A_CTL: begin
                    n.ack_en = wdata_in[`TWS_B_EA];
                    n.start_request    = wdata_in[`TWS_B_STA];
                    n.stop_request    = wdata_in[`TWS_B_STO];
                    n.en     = wdata_in[`TWS_B_EN];
                end
                `TWS_A_DATA: begin
                    // Data is only safe to change while the engine waits
                    if (r.flag) begin
                        n.dat = wdata_in;
                        n.wc  = 1'b0;
                    end else begin
                        n.wc  = 1'b1;
                    end
                end
                `TWS_A_OWN: n.own = wdata_in;
                `TWS_A_EVT: n.evt = r.evt & ~wdata_in[2:0];
                `TWS_A_MSK: n.msk = wdata_in[2:0];
                default: begin
                end
            endcase
        end

        // Flag clear restarts the engine from where it waited
        if (clr) begin
            n.flag = 1'b0;
            n.hold = 1'b0;
            n.arb  = 1'b0;
            case (r.st)
                ST_TX_BIT: begin
                    n.sh   = r.dat;
                    n.cnt  = 4'h0;
                    n.last = !wdata_in[`TWS_B_EA];
                end
                ST_DONE: begin
                    if (wdata_in[`TWS_B_STA]) begin
                        n.spend = 1'b1;
                    end
                end
                ST_ERR: begin
                    if (wdata_in[`TWS_B_STO]) begin
                        n.st  = ST_IDLE;
                        n.stop_request = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Master logic reports a lost address arbitration
        if (arb_lost_in) begin
            n.arb = 1'b1;
        end

        // Bus activity
        // Clearing the enable drops any transfer at once, wherever it stood
        if (!r.en) begin
            n.st   = ST_IDLE;
            n.hold = 1'b0;
            n.cnt  = 4'h0;
        end else if (r.st != ST_SGEN && (line.start_det || line.stop_det)) begin
            n.busy = line.start_det;
            if (bad) begin
                n.st   = ST_ERR;
                n.flag = 1'b1;
                n.code = `TWS_ST_BUSERR;
                n.hold = 1'b0;
                n.evt  = n.evt | `TWS_EV_JOB | `TWS_EV_ERR;
            end else if (r.st != ST_ERR) begin
                // Unaddressed states simply follow the bus
                n.st  = line.start_det ? ST_ADDR : ST_IDLE;
                n.cnt = 4'h0;
            end
        end else begin
            case (r.st)
                ST_ADDR: begin
                    if (line.scl_rise) begin
                        n.sh  = {r.sh[6:0], line.sda};
                        n.cnt = r.cnt + 4'h1;
                    end else if (line.scl_fall && r.cnt == 4'h8) begin
                        // No read match on general call; only the own address counts
                        // Read from our address only while acks are enabled
                        if (r.sh[7:1] == r.own[7:1] && r.sh[0] && r.ack_en && !r.flag) begin
                            n.st = ST_ADDR_ACK;
                        end else begin
                            n.st = ST_DONE;
                        end
                        n.cnt = 4'h0;
                    end
                end
                ST_ADDR_ACK: begin
                    if (line.scl_fall) begin
                        n.st   = ST_TX_BIT;
                        n.flag = 1'b1;
                        n.hold = 1'b1;
                        n.code = r.arb ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R;
                        n.evt  = n.evt | `TWS_EV_JOB;
                    end
                end
                ST_TX_BIT: begin
                    if (line.scl_fall && !r.flag) begin
                        if (r.cnt == 4'h7) begin
                            n.st  = ST_TX_ACK;
                            n.cnt = 4'h0;
                        end else begin
                            n.sh  = {r.sh[6:0], 1'b1};
                            n.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (line.scl_rise) begin
                        n.ackv = line.sda;
                    end else if (line.scl_fall) begin
                        n.flag = 1'b1;
                        n.hold = 1'b1;
                        n.evt  = n.evt | `TWS_EV_JOB;
                        if (r.ackv) begin
                            n.st   = ST_DONE;
                            n.code = `TWS_ST_DATA_NACK;
                        end else if (r.last) begin
                            n.st   = ST_DONE;
                            n.code = `TWS_ST_LAST_ACK;
                        end else begin
                            n.st   = ST_TX_BIT;
                            n.code = `TWS_ST_DATA_ACK;
                        end
                    end
                end
                ST_IDLE, ST_DONE: begin
                    // Own START only on a free and idle bus
                    if (r.spend && !r.busy && !r.flag && line.scl && line.sda) begin
                        n.st   = ST_SGEN;
                        n.gcnt = 6'h00;
                    end
                end
                ST_SGEN: begin
                    if (r.gcnt == HOLD_LAST) begin
                        n.st    = ST_IDLE;
                        n.spend = 1'b0;
                        n.busy  = 1'b1;
                        n.evt   = n.evt | `TWS_EV_START;
                    end else begin
                        n.gcnt = r.gcnt + 6'h01;
                    end
                end
                default: begin
                end
            endcase
        end

        // Pin drives; unaddressed states leave data released
        n.sda_oe = n.st == ST_ADDR_ACK || n.st == ST_SGEN ||
                   (n.st == ST_TX_BIT && !n.flag && !n.sh[7]);
        // Clock released one cycle after data settles
        n.scl_oe = n.hold || r.hold;
        // Level interrupt follows the sticky events through the mask
        n.irq    = |(n.evt & n.msk);
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            r <= `TWS_CORE_RST;
        end else begin
            r <= n;
        end
    end

    // Open-drain pins only ever pull low
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;
    assign scl_oe_out = r.scl_oe;
    assign sda_oe_out = r.sda_oe;
    assign rdata_out  = r.rdata;
    assign irq_out    = r.irq;

    // ==========================================================
    // Checks
    // State is registered, so most checks look one edge after the event
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    a_idle_code: assert property (
        !r.flag && rd_in && addr_in == `TWS_A_STAT |=> rdata_out == `TWS_ST_NOINFO)
        else $error("status not 0xF8 with flag clear");
    a_low_bits_zero: assert property (
        rd_in && addr_in == `TWS_A_STAT |=> rdata_out[2:0] == 3'b000)
        else $error("status low bits not zero");
    a_sla_r_code: assert property (
        r.st == ST_ADDR_ACK && line.scl_fall && quiet && !r.arb
        |=> r.flag && r.code == `TWS_ST_SLA_R && r.st == ST_TX_BIT)
        else $error("own read address not reported as 0xA8");
    a_arb_code: assert property (
        r.st == ST_ADDR_ACK && line.scl_fall && quiet && r.arb && !clr
        |=> r.flag && r.code == `TWS_ST_ARB_SLA_R)
        else $error("lost arbitration read not reported as 0xB0");
    a_ack_more: assert property (
        r.st == ST_TX_ACK && line.scl_fall && quiet && !r.ackv && !r.last
        |=> r.flag && r.code == `TWS_ST_DATA_ACK && r.st == ST_TX_BIT)
        else $error("acked byte not reported as 0xB8");
    a_nack_end: assert property (
        r.st == ST_TX_ACK && line.scl_fall && quiet && r.ackv
        |=> r.flag && r.code == `TWS_ST_DATA_NACK && r.st == ST_DONE)
        else $error("nacked byte not reported as 0xC0");
    a_last_acked: assert property (
        r.st == ST_TX_ACK && line.scl_fall && quiet && !r.ackv && r.last
        |=> r.flag && r.code == `TWS_ST_LAST_ACK && r.st == ST_DONE)
        else $error("acked last byte not reported as 0xC8");
    a_bus_err: assert property (
        r.en && bad && (line.start_det || line.stop_det)
        |=> r.flag && r.code == `TWS_ST_BUSERR && r.st == ST_ERR)
        else $error("illegal condition not flagged as bus error");
    a_err_recover: assert property (
        r.st == ST_ERR && clr && wdata_in[`TWS_B_STO]
        |=> r.st == ST_IDLE && !r.stop_request && !r.flag && !sda_oe_out && !scl_oe_out)
        else $error("bus error recovery failed");
    a_last_latch: assert property (
        r.st == ST_TX_BIT && clr |=> r.last == !$past(wdata_in[`TWS_B_EA]) && r.cnt == 4'h0)
        else $error("last byte marker not taken from ack enable");
    a_no_match: assert property (
        r.st == ST_ADDR && line.scl_fall && r.cnt == 4'h8 && quiet && !r.ack_en
        |=> r.st == ST_DONE ##1 !sda_oe_out)
        else $error("address matched with acks disabled");
    a_start_arm: assert property (
        r.st == ST_DONE && clr && wdata_in[`TWS_B_STA] |=> r.spend)
        else $error("start request not armed");
    a_ignore_tail: assert property (
        r.st == ST_DONE |-> !sda_oe_out)
        else $error("data driven while unaddressed");
    a_stretch_hold: assert property (
        $rose(r.flag) && r.code != `TWS_ST_BUSERR |-> scl_oe_out [*2])
        else $error("clock not stretched while flag set");
    a_err_release: assert property (
        r.st == ST_ERR |-> !sda_oe_out && !scl_oe_out)
        else $error("lines held in bus error state");

    // Main scenarios the bench should reach
    c_read_entry: cover property (r.st == ST_ADDR_ACK ##[1:20] r.st == ST_TX_BIT && r.flag);
    c_nack_end:   cover property (r.code == `TWS_ST_DATA_NACK && r.flag);
    c_bus_err:    cover property (r.st == ST_ERR ##[1:50] r.st == ST_IDLE);
    c_start_gen:  cover property (r.st == ST_SGEN ##[1:60] r.st == ST_IDLE);
    c_last_ack:   cover property (r.code == `TWS_ST_LAST_ACK && r.flag);

endmodule

// ===== sim/tws_bus_master.sv
`timescale 1ns/10ps
// ==========================================================
// Bus master model: open drain, a one releases the line to its pull-up
module tws_bus_master (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_rel_out,
    output logic      sda_rel_out
);
    localparam int HALF = 400;
    logic          scl_rel;
    logic          sda_rel;
    wire           scl_w = scl_in;
    wire           sda_w = sda_in;

    assign scl_rel_out = scl_rel;
    assign sda_rel_out = sda_rel;

    // Idle bus: both lines released, the clock stands still between frames
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end

    // One clock pulse; waiting on the wire honours the slave's stretch
    task automatic pulse(input logic b, output logic s);
        sda_rel = b;
        #(HALF / 2);
        scl_rel = 1'b1;
        wait (scl_w);
        #(HALF / 2 + 13);
        s = sda_w;
        #(HALF / 2);
        scl_rel = 1'b0;
        #(HALF / 2);
    endtask

    // START; inside a byte it is an illegal repeated START
    task automatic start_cond();
        #(HALF + 37);
        sda_rel = 1'b1;
        #(HALF / 2);
        scl_rel = 1'b1;
        wait (scl_w);
        #(HALF / 2);
        sda_rel = 1'b0;
        #(HALF / 2);
        scl_rel = 1'b0;
        #(HALF / 2);
    endtask

    // STOP; returns at once so a follow-up START can be timed
    task automatic stop_cond();
        #37;
        sda_rel = 1'b0;
        #(HALF / 2);
        scl_rel = 1'b1;
        wait (scl_w);
        #(HALF / 2);
        sda_rel = 1'b1;
    endtask

    // Address bits MSB first; a short count leaves the byte open
    task automatic send_byte(input logic [7:0] b, input int nbits, output logic ack);
        logic s;
        #37;
        for (int i = 7; i > 7 - nbits; i--) pulse(b[i], s);
        ack = 1'b1;
        if (nbits == 8) pulse(1'b1, ack);
    endtask

    // Data byte MSB first, then the answer: ack drives the line low
    task automatic read_byte(input logic ack, output logic [7:0] b);
        logic s;
        #37;
        for (int i = 7; i >= 0; i--) pulse(1'b1, b[i]);
        pulse(~ack, s);
    endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/10ps
`include "tws_consts.svh"
module tb;
    // ==========================================================
    // Signals and transfer table
    typedef struct packed {
        logic       first;
        logic       arb;
        logic [7:0] dat;
        logic       ea;
        logic       mack;
        logic [7:0] code;
        logic [7:0] clr;
    } tws_row_t;
    localparam logic [7:0] RUN = 8'h44; // Enable plus acknowledge-enable
    localparam tws_row_t ROWS [4] = '{
        '{1'b1, 1'b0, 8'h5A, 1'b1, 1'b1, `TWS_ST_DATA_ACK, 8'h00},
        '{1'b0, 1'b0, 8'hC3, 1'b0, 1'b0, `TWS_ST_DATA_NACK, 8'hE4},
        '{1'b1, 1'b0, 8'h0F, 1'b0, 1'b1, `TWS_ST_LAST_ACK, 8'hC4},
        '{1'b1, 1'b1, 8'h96, 1'b0, 1'b0, `TWS_ST_DATA_NACK, 8'h84}
    };
    logic       ref_clk;
    logic       rst      = 1'b1;
    logic [2:0] addr     = 3'h0;
    logic [7:0] wdata    = 8'h00;
    logic       wr_s     = 1'b0;
    logic       rd_s     = 1'b0;
    logic       arb      = 1'b0;
    logic [7:0] rdata;
    logic       scl_o, scl_oe, sda_o, sda_oe, irq, scl_rel, sda_rel;
    wire        scl_w    = scl_rel & (~scl_oe | scl_o);
    wire        sda_w    = sda_rel & (~sda_oe | sda_o);
    int         failures = 0;
    int         n_tests  = 0;
    int         cycles   = 0;
    int         n;

    tws_slave_tx tws_slave_tx_inst (.ref_clk_in(ref_clk), .rst_in(rst), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
        .arb_lost_in(arb), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .irq_out(irq));
    tws_bus_master tws_bus_master_inst (.scl_in(scl_w), .sda_in(sda_w),
        .scl_rel_out(scl_rel), .sda_rel_out(sda_rel));

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Hang guard, far above the thousand or so cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    // ==========================================================
    // Tasks
    task automatic summarize();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    // Outputs are looked at just after the edge, once its updates landed
    task automatic cyc();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk);
        wr_s <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            cyc();
            n++;
        end
        chk("irq", 8'h01, {7'h00, irq});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        tws_row_t   r;
        logic [7:0] b;
        logic       ack;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        wr(`TWS_A_OWN, 8'hA4);
        wr(`TWS_A_MSK, 8'h01);
        wr(`TWS_A_CTL, RUN);
        // Table rows: addressing, one byte each, then the ending of the transfer
        for (int i = 0; i < 4; i++) begin
            r = ROWS[i];
            if (r.first) begin
                @(posedge ref_clk);
                arb <= r.arb;
                @(posedge ref_clk);
                arb <= 1'b0;
                tws_bus_master_inst.start_cond();
                tws_bus_master_inst.send_byte(8'hA5, 8, ack);
                chk("addr_ack", 8'h00, {7'h00, ack});
                wait_irq();
                b = r.arb ? `TWS_ST_ARB_SLA_R : `TWS_ST_SLA_R;
                rchk(`TWS_A_STAT, b, "addr_code");
                wr(`TWS_A_EVT, 8'h07);
            end
            wr(`TWS_A_DATA, r.dat);
            wr(`TWS_A_CTL, {1'b1, r.ea, 6'h04});
            tws_bus_master_inst.read_byte(r.mack, b);
            chk("tx_byte", r.dat, b);
            wait_irq();
            chk("stretch", 8'h01, {7'h00, scl_oe});
            rchk(`TWS_A_STAT, r.code, "byte_code");
            wr(`TWS_A_EVT, 8'h07);
            if (r.clr != 8'h00) begin
                wr(`TWS_A_CTL, r.clr);
                rchk(`TWS_A_STAT, `TWS_ST_NOINFO, "idle_code");
                if (r.mack) begin
                    tws_bus_master_inst.read_byte(1'b0, b);
                    chk("ones", 8'hFF, b);
                end
                tws_bus_master_inst.stop_cond();
                if (r.clr[5]) begin
                    n = 0;
                    while (sda_oe !== 1'b1 && n < 500) begin
                        cyc();
                        n++;
                    end
                    n = 0;
                    while (sda_oe === 1'b1 && n < 100) begin
                        cyc();
                        n++;
                    end
                    chk("start_len", 8'h28, n[7:0]);
                    rchk(`TWS_A_EVT, 8'h04, "start_evt");
                    wr(`TWS_A_EVT, 8'h07);
                    wr(`TWS_A_CTL, RUN);
                end
            end
        end
        // Acknowledge-enable was left low: own address must go unanswered
        tws_bus_master_inst.start_cond();
        tws_bus_master_inst.send_byte(8'hA5, 8, ack);
        chk("no_ack", 8'h01, {7'h00, ack});
        tws_bus_master_inst.stop_cond();
        wr(`TWS_A_CTL, RUN);
        // START three bits into an address byte, then mask and clear the interrupt
        tws_bus_master_inst.start_cond();
        tws_bus_master_inst.send_byte(8'hA5, 3, ack);
        tws_bus_master_inst.start_cond();
        wait_irq();
        rchk(`TWS_A_STAT, `TWS_ST_BUSERR, "err_code");
        chk("err_lines", 8'h00, {6'h00, scl_oe, sda_oe});
        wr(`TWS_A_MSK, 8'h00);
        cyc();
        chk("irq_masked", 8'h00, {7'h00, irq});
        wr(`TWS_A_MSK, 8'h01);
        cyc();
        chk("irq_unmasked", 8'h01, {7'h00, irq});
        wr(`TWS_A_EVT, 8'h07);
        cyc();
        chk("irq_cleared", 8'h00, {7'h00, irq});
        wr(`TWS_A_CTL, 8'hD4);
        rchk(`TWS_A_CTL, RUN, "err_ctl");
        rchk(`TWS_A_STAT, `TWS_ST_NOINFO, "err_idle");
        chk("err_free", 8'h00, {6'h00, scl_oe, sda_oe});
        tws_bus_master_inst.stop_cond();
        // Data write with the flag clear is refused and flagged
        wr(`TWS_A_DATA, 8'h11);
        rchk(`TWS_A_CTL, 8'h4C, "collision");
        cyc();
        chk("rdata_idle", 8'h00, rdata);
        // Reset in mid-run, then an unmapped index
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rchk(`TWS_A_CTL, 8'h00, "rst_ctl");
        rchk(`TWS_A_STAT, `TWS_ST_NOINFO, "rst_stat");
        rchk(3'h7, 8'h00, "unmapped");
        chk("rst_outs", 8'h00, {3'h0, scl_o, sda_o, irq, scl_oe, sda_oe});
        summarize();
    end
endmodule
